/* File: logic/evp_exception_map.sv */
`timescale 1ns/1ps
`include "evp_defines.svh"
// Function
// - reset, nmi, hard fault fixed at -3,-2,-1
// - irq number equals exception number minus 16
// - status reads exception number, not irq number
// - one more instruction allowed before asynchronous entry
// - configurable exceptions disableable; fixed ones not
// - stack pointer at 0, handler at 4*exception
// - irq vectors from 0x40, step 4, to 0x184
// - reset puts table base at zero
// - base relocatable within 0x80 to 0x3ffff80
// - irqs 0 to 81 routed via vector slots
// - system exceptions kept separate from peripheral irqs
// - lower priority value is more urgent
// - configurable priorities 0 to 15
// - equal priority: lowest exception number first
// - equal priority never preempts running handler
module evp_exception_map (
    input wire logic clock, // core clock, 10 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic nmi_req, // non-maskable interrupt level
    input wire logic hard_req, // hard fault pulse
    input wire logic mem_req, // memory management fault pulse
    input wire logic bus_req, // bus fault pulse
    input wire logic usage_req, // usage fault pulse
    input wire logic svc_req, // supervisor call pulse
    input wire logic psv_req, // pended service call pulse
    input wire logic tick_req, // system tick pulse
    input wire logic [81:0] irq_req, // peripheral interrupt pulses
    input wire logic [5:0] sys_enable, // per-system-handler enables
    input wire logic [81:0] irq_enable, // interrupt enables
    input wire logic [3:0] sys_prio [6], // mem,bus,usage,svc,psv,tick priorities
    input wire logic [3:0] irq_prio [82], // peripheral priorities
    input wire logic base_wr, // privileged write to vector_base_offset
    input wire logic [31:0] base_wdata, // value written
    input wire logic instr_done, // core retired one instruction
    input wire logic entry_ack, // core fetched vector and entered handler
    input wire logic handler_done, // active handler returned
    output logic entry_req, // handler entry request
    output logic [31:0] vec_addr, // vector slot address to fetch
    output logic [7:0] active_exception_status, // active exception number
    output logic signed [8:0] active_irq_num, // active interrupt number
    output logic signed [4:0] active_prio, // running priority
    output logic active_is_system, // active one is a system exception other than reset
    output logic active_is_fault, // active one is a fault
    output logic [31:0] vector_base_offset // table base
);
    evp_pkg::evp_state_t state_reg;
    logic [5:0] sys_pend_reg;
    logic [81:0] irq_pend_reg;
    logic nmi_pend_reg;
    logic hard_pend_reg;
    logic [7:0] sel_exc_reg;
    logic signed [4:0] sel_prio_reg;
    logic [31:0] base_next;
    logic [31:0] addr_w;
    logic [5:0] sys_raw;
    logic [5:0] sys_clear;
    logic [81:0] irq_clear;
    // candidate array: nmi, hard, 6 system + 82 irq leaves, padded to 128 for the tree
    logic c_valid [255];
    logic signed [4:0] c_prio [255];
    logic [7:0] c_exc [255];
    logic top_valid;
    logic signed [4:0] top_prio;
    logic [7:0] top_exc;
    logic preempt;

    assign sys_raw = {tick_req, psv_req, svc_req, usage_req, bus_req, mem_req};

    // pending latches; a new request wins over the clear in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sys_pend_reg <= 6'h00;
            irq_pend_reg <= '0;
            nmi_pend_reg <= 1'b0;
            hard_pend_reg <= 1'b0;
        end else begin
            sys_pend_reg <= (sys_pend_reg & ~sys_clear) | sys_raw;
            irq_pend_reg <= (irq_pend_reg & ~irq_clear) | irq_req;
            nmi_pend_reg <= nmi_req | (nmi_pend_reg & ~(entry_ack && state_reg ==
                evp_pkg::EVP_FETCH && sel_exc_reg == `EVP_EXC_NMI));
            hard_pend_reg <= hard_req | (hard_pend_reg & ~(entry_ack && state_reg ==
                evp_pkg::EVP_FETCH && sel_exc_reg == `EVP_EXC_HARD));
        end
    end

    // clear the entry that was taken
    genvar g;
    generate
        for (g = 0; g < 88; g++) begin : g_clr
            if (g < 6) begin : g_s
                assign sys_clear[g] = entry_ack && state_reg == evp_pkg::EVP_FETCH
                    && sel_exc_reg == c_exc[129 + g];
            end else begin : g_i
                assign irq_clear[g - 6] = entry_ack && state_reg == evp_pkg::EVP_FETCH
                    && sel_exc_reg == 8'(`EVP_EXC_IRQ0 + (g - 6));
            end
        end
    endgenerate

    // leaves: disabled entries are never candidates; fixed ones always are
    localparam logic [7:0] SYS_EXC [6] = '{`EVP_EXC_MEM, `EVP_EXC_BUS, `EVP_EXC_USAGE,
        `EVP_EXC_SVC, `EVP_EXC_PSV, `EVP_EXC_TICK};
    generate
        for (g = 0; g < 128; g++) begin : g_leaf
            if (g == 0) begin : g_nmi
                assign c_valid[127] = nmi_pend_reg;
                assign c_prio[127] = `EVP_PRIO_NMI;
                assign c_exc[127] = `EVP_EXC_NMI;
            end else if (g == 1) begin : g_hard
                assign c_valid[128] = hard_pend_reg;
                assign c_prio[128] = `EVP_PRIO_HARD;
                assign c_exc[128] = `EVP_EXC_HARD;
            end else if (g < 8) begin : g_sys
                assign c_valid[127 + g] = sys_pend_reg[g - 2] & sys_enable[g - 2];
                assign c_prio[127 + g] = {1'b0, sys_prio[g - 2]};
                assign c_exc[127 + g] = SYS_EXC[g - 2];
            end else if (g < 90) begin : g_irq
                assign c_valid[127 + g] = irq_pend_reg[g - 8] & irq_enable[g - 8];
                assign c_prio[127 + g] = {1'b0, irq_prio[g - 8]};
                assign c_exc[127 + g] = 8'(`EVP_EXC_IRQ0 + (g - 8));
            end else begin : g_pad
                assign c_valid[127 + g] = 1'b0;
                assign c_prio[127 + g] = `EVP_PRIO_IDLE;
                assign c_exc[127 + g] = 8'hff;
            end
        end
        for (g = 0; g < 127; g++) begin : g_node
            evp_prio_cmp u_cmp (
                .a_valid(c_valid[2 * g + 1]),
                .a_prio(c_prio[2 * g + 1]),
                .a_exc(c_exc[2 * g + 1]),
                .b_valid(c_valid[2 * g + 2]),
                .b_prio(c_prio[2 * g + 2]),
                .b_exc(c_exc[2 * g + 2]),
                .w_valid(c_valid[g]),
                .w_prio(c_prio[g]),
                .w_exc(c_exc[g])
            );
        end
    endgenerate
    assign top_valid = c_valid[0];
    assign top_prio = c_prio[0];
    assign top_exc = c_exc[0];

    // strictly more urgent only, so an equal level waits pending; the idle code
    // reads as -16 signed, so thread mode is told by the status, not the compare
    assign preempt = top_valid && (active_exception_status == 8'h00 ||
        top_prio < active_prio);

    // entry sequence; one nesting level only, return drops to idle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= evp_pkg::EVP_IDLE;
            sel_exc_reg <= `EVP_EXC_RESET;
            sel_prio_reg <= `EVP_PRIO_IDLE;
        end else begin
            case (state_reg)
                evp_pkg::EVP_IDLE, evp_pkg::EVP_ACTIVE: begin
                    if (preempt) begin
                        sel_exc_reg <= top_exc;
                        sel_prio_reg <= top_prio;
                        // hard, mem, usage faults and svc are synchronous; the rest, bus fault too, may let one instruction go
                        state_reg <= (top_exc == `EVP_EXC_HARD || top_exc ==
                            `EVP_EXC_MEM || top_exc == `EVP_EXC_USAGE ||
                            top_exc == `EVP_EXC_SVC) ? evp_pkg::EVP_FETCH
                            : evp_pkg::EVP_GRACE;
                    end else if (handler_done && state_reg == evp_pkg::EVP_ACTIVE) begin
                        state_reg <= evp_pkg::EVP_IDLE;
                    end
                end
                evp_pkg::EVP_GRACE: begin
                    if (instr_done) begin
                        state_reg <= evp_pkg::EVP_FETCH;
                    end
                end
                evp_pkg::EVP_FETCH: begin
                    if (entry_ack) begin
                        state_reg <= evp_pkg::EVP_ACTIVE;
                    end
                end
                default: state_reg <= evp_pkg::EVP_IDLE;
            endcase
        end
    end

    // handler status seen by the core; reset itself is the first active one
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            active_exception_status <= `EVP_EXC_RESET;
            active_irq_num <= 9'sh1f1;
            active_prio <= `EVP_PRIO_RESET;
            active_is_system <= 1'b0;
            active_is_fault <= 1'b0;
        end else if (state_reg == evp_pkg::EVP_FETCH && entry_ack) begin
            active_exception_status <= sel_exc_reg;
            active_irq_num <= $signed({1'b0, sel_exc_reg}) - 9'sh010;
            active_prio <= sel_prio_reg;
            active_is_system <= sel_exc_reg < `EVP_EXC_IRQ0;
            active_is_fault <= sel_exc_reg >= `EVP_EXC_HARD &&
                sel_exc_reg <= `EVP_EXC_USAGE;
        end else if (handler_done && (state_reg == evp_pkg::EVP_ACTIVE ||
            state_reg == evp_pkg::EVP_IDLE) && !preempt) begin
            active_exception_status <= 8'h00;
            active_irq_num <= 9'sh000;
            active_prio <= `EVP_PRIO_IDLE;
            active_is_system <= 1'b0;
            active_is_fault <= 1'b0;
        end
    end

    // base register: an out-of-range write is clamped to the legal window
    always_comb begin
        base_next = base_wdata & `EVP_BASE_MASK;
        if (base_next < `EVP_BASE_MIN) begin
            base_next = `EVP_BASE_MIN;
        end else if (base_next > `EVP_BASE_MAX) begin
            base_next = `EVP_BASE_MAX;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            vector_base_offset <= `EVP_BASE_RESET;
        end else if (base_wr) begin
            vector_base_offset <= base_next;
        end
    end

    evp_vec_addr u_addr (
        .base(vector_base_offset),
        .exc(sel_exc_reg),
        .addr(addr_w)
    );

    // request and slot address held steady while the core fetches
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            entry_req <= 1'b0;
            vec_addr <= `EVP_BASE_RESET + `EVP_OFS_RESET;
        end else begin
            entry_req <= state_reg == evp_pkg::EVP_FETCH && !entry_ack;
            vec_addr <= addr_w;
        end
    end

    // checks
    reset_base_zero_a: assert property (@(posedge clock)
        !rst_n |=> vector_base_offset == 32'h0000_0000)
        else $error("base not zero after reset");
    base_in_window_a: assert property (@(posedge clock) disable iff (!rst_n)
        $past(base_wr) |-> vector_base_offset >= 32'h0000_0080
        && vector_base_offset <= 32'h03ff_ff80)
        else $error("base outside window");
    no_equal_preempt_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_ACTIVE && top_prio >= active_prio |=>
        state_reg inside {evp_pkg::EVP_ACTIVE, evp_pkg::EVP_IDLE})
        else $error("equal priority preempted");
    irq_number_a: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 active_prio != 5'sh10 |-> active_irq_num ==
        $signed({1'b0, active_exception_status}) - 9'sh010)
        else $error("irq number mismatch");
    status_exc_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_FETCH && entry_ack |=>
        active_exception_status == $past(sel_exc_reg))
        else $error("status not exception number");
    grace_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_GRACE && !instr_done |=>
        state_reg == evp_pkg::EVP_GRACE)
        else $error("grace left early");
    no_reserved_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_FETCH |-> !(sel_exc_reg inside {8'h07, 8'h08,
        8'h09, 8'h0a, 8'h0c, 8'h0d}))
        else $error("reserved exception raised");
    slot_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_FETCH ##1 state_reg == evp_pkg::EVP_FETCH |->
        vec_addr == vector_base_offset + {22'h0, sel_exc_reg, 2'b00})
        else $error("wrong vector slot");
    fixed_prio_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_FETCH && sel_exc_reg == 8'h02 |->
        sel_prio_reg == 5'sh1e)
        else $error("nmi priority not fixed");
    hard_prio_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_FETCH && sel_exc_reg == 8'h03 |->
        sel_prio_reg == 5'sh1f)
        else $error("hard fault priority not fixed");
    request_stands_a: assert property (@(posedge clock) disable iff (!rst_n)
        entry_req && !entry_ack |=> entry_req)
        else $error("entry request dropped before acknowledge");
    fault_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_FETCH && entry_ack |=>
        active_is_fault == ($past(sel_exc_reg) inside {8'h03, 8'h04, 8'h05, 8'h06}))
        else $error("fault class flag wrong");
    cov_irq_entry: cover property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_FETCH && entry_ack && sel_exc_reg >= 8'h10);
    cov_nest: cover property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_ACTIVE && preempt);
    cov_relocate: cover property (@(posedge clock) disable iff (!rst_n) base_wr);
    cov_fault_entry: cover property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_FETCH && entry_ack && sel_exc_reg == 8'h03);
    cov_grace_exit: cover property (@(posedge clock) disable iff (!rst_n)
        state_reg == evp_pkg::EVP_GRACE && instr_done);
endmodule : evp_exception_map

/* File: logic/evp_defines.svh */
`ifndef EVP_DEFINES_SVH
`define EVP_DEFINES_SVH

// exception numbers
`define EVP_EXC_RESET 8'h01
`define EVP_EXC_NMI 8'h02
`define EVP_EXC_HARD 8'h03
`define EVP_EXC_MEM 8'h04
`define EVP_EXC_BUS 8'h05
`define EVP_EXC_USAGE 8'h06
`define EVP_EXC_SVC 8'h0b
`define EVP_EXC_PSV 8'h0e
`define EVP_EXC_TICK 8'h0f
`define EVP_EXC_IRQ0 8'h10
`define EVP_NUM_IRQ 82
`define EVP_NUM_SYS 6
// priorities: 5-bit signed, fixed ones negative
`define EVP_PRIO_RESET 5'h1d
`define EVP_PRIO_NMI 5'h1e
`define EVP_PRIO_HARD 5'h1f
`define EVP_PRIO_IDLE 5'h10
// table offsets and base limits
`define EVP_OFS_INIT_SP 32'h0000_0000
`define EVP_OFS_RESET 32'h0000_0004
`define EVP_OFS_IRQ0 32'h0000_0040
`define EVP_OFS_IRQ_LAST 32'h0000_03fc
`define EVP_BASE_RESET 32'h0000_0000
`define EVP_BASE_MIN 32'h0000_0080
`define EVP_BASE_MAX 32'h03ff_ff80
`define EVP_BASE_MASK 32'hffff_ff80

`endif

/* File: logic/evp_pkg.sv */
package evp_pkg;
    typedef logic [7:0] evp_exc_t;
    typedef logic signed [8:0] evp_irqn_t;
    typedef logic signed [4:0] evp_prio_t;
    typedef enum logic [1:0] {
        EVP_IDLE = 2'b00,
        EVP_GRACE = 2'b01,
        EVP_FETCH = 2'b11,
        EVP_ACTIVE = 2'b10
    } evp_state_t;
endpackage : evp_pkg

/* File: logic/evp_prio_cmp.sv */
`timescale 1ns/1ps
`include "evp_defines.svh"
// one tournament stage: keeps the more urgent of two candidates
module evp_prio_cmp (
    input wire logic a_valid, // candidate a pending
    input wire logic signed [4:0] a_prio, // candidate a priority
    input wire logic [7:0] a_exc, // candidate a exception number
    input wire logic b_valid, // candidate b pending
    input wire logic signed [4:0] b_prio, // candidate b priority
    input wire logic [7:0] b_exc, // candidate b exception number
    output logic w_valid, // winner pending
    output logic signed [4:0] w_prio, // winner priority
    output logic [7:0] w_exc // winner exception number
);
    logic pick_b;
    // lower value wins; ties go to the lower exception number
    always_comb begin
        pick_b = 1'b0;
        if (!a_valid) begin
            pick_b = b_valid;
        end else if (b_valid) begin
            if (b_prio < a_prio) begin
                pick_b = 1'b1;
            end else if (b_prio == a_prio && b_exc < a_exc) begin
                pick_b = 1'b1;
            end
        end
    end
    assign w_valid = a_valid | b_valid;
    assign w_prio = pick_b ? b_prio : a_prio;
    assign w_exc = pick_b ? b_exc : a_exc;
endmodule : evp_prio_cmp

/* File: logic/evp_vec_addr.sv */
`timescale 1ns/1ps
`include "evp_defines.svh"
// vector slot address: base plus four times the exception number
module evp_vec_addr (
    input wire logic [31:0] base, // table base
    input wire logic [7:0] exc, // exception number
    output logic [31:0] addr // word address of the slot
);
    // slot 0 holds the initial stack pointer, slot 1 reset
    assign addr = base + {22'h0, exc, 2'b00};
endmodule : evp_vec_addr

/* File: test/evp_core_model.sv */
`timescale 1ns/1ps
// core-side stand-in: retires instructions and acknowledges handler entry
module evp_core_model (
    input wire logic clock, // core clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic entry_req, // entry request from the map
    input wire logic [31:0] vec_addr, // slot to fetch
    input wire logic stall, // hold off retiring instructions
    input wire logic [3:0] ack_wait, // cycles before acknowledging entry
    output logic instr_done, // one instruction retired
    output logic entry_ack, // handler entered
    output logic [31:0] fetched_addr, // slot fetched at last entry
    output logic [31:0] handler_pc, // slot address with bit 0 set, standing in for the handler start
    output logic [31:0] n_entries // entries so far
);
    logic [3:0] wait_reg;
    logic [1:0] gap_reg;

    // retire one instruction every fourth cycle unless stalled
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gap_reg <= 2'h0;
            instr_done <= 1'b0;
        end else begin
            gap_reg <= gap_reg + 2'h1;
            instr_done <= !stall && (gap_reg == 2'h3);
        end
    end

    // a slow fetch is a wait before the acknowledge; ack never outlives the request
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wait_reg <= 4'h0;
            entry_ack <= 1'b0;
            fetched_addr <= 32'h0;
            handler_pc <= 32'h0;
            n_entries <= 32'h0;
        end else if (entry_ack) begin
            entry_ack <= 1'b0;
            wait_reg <= 4'h0;
            fetched_addr <= vec_addr;
            handler_pc <= {vec_addr[31:1], 1'b1};
            n_entries <= n_entries + 32'h1;
        end else if (entry_req) begin
            if (wait_reg == ack_wait) begin
                entry_ack <= 1'b1;
            end else begin
                wait_reg <= wait_reg + 4'h1;
            end
        end
    end
endmodule : evp_core_model

/* File: test/evp_exception_map_tb.sv */
`timescale 1ns/1ps
module evp_exception_map_tb;
    logic clock, rst_n, nmi_req, hard_req, mem_req, bus_req, usage_req, svc_req, psv_req;
    logic tick_req, base_wr, instr_done, entry_ack, handler_done, stall, entry_req;
    logic active_is_system, active_is_fault;
    logic [81:0] irq_req, irq_enable;
    logic [5:0] sys_enable;
    logic [3:0] sys_prio [6];
    logic [3:0] irq_prio [82];
    logic [3:0] ack_wait;
    logic [31:0] base_wdata, vec_addr, vector_base_offset, fetched_addr, n_entries, exp_base;
    logic [7:0] active_exception_status;
    logic signed [8:0] active_irq_num;
    logic signed [4:0] active_prio;
    int n_fail, n_compared;

    evp_exception_map i_evp_exception_map (.clock, .rst_n, .nmi_req, .hard_req, .mem_req,
        .bus_req, .usage_req, .svc_req, .psv_req, .tick_req, .irq_req, .sys_enable,
        .irq_enable, .sys_prio, .irq_prio, .base_wr, .base_wdata, .instr_done, .entry_ack,
        .handler_done, .entry_req, .vec_addr, .active_exception_status, .active_irq_num,
        .active_prio, .active_is_system, .active_is_fault, .vector_base_offset);
    evp_core_model i_evp_core_model (.clock, .rst_n, .entry_req, .vec_addr, .stall, .ack_wait,
        .instr_done, .entry_ack, .fetched_addr, .handler_pc(), .n_entries);

    // free-running core clock, 100 ns
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task complete_run;
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // k: 0 nmi, 1 hard, 2 mem, 3 bus, 4 usage, 5 svc, 6 pended, 7 tick, else irq mask
    task fire(input int k, input logic [81:0] m);
        @(posedge clock);
        case (k)
            0: nmi_req <= 1'b1;
            1: hard_req <= 1'b1;
            2: mem_req <= 1'b1;
            3: bus_req <= 1'b1;
            4: usage_req <= 1'b1;
            5: svc_req <= 1'b1;
            6: psv_req <= 1'b1;
            7: tick_req <= 1'b1;
            default: irq_req <= m;
        endcase
        @(posedge clock);
        {nmi_req, hard_req, mem_req, bus_req, usage_req, svc_req, psv_req, tick_req} <= 8'h0;
        irq_req <= '0;
    endtask : fire

    // bounded wait for the model to take an entry; a hang closes the run
    task take(input logic [7:0] exc, input logic [4:0] prio, input logic sys, input logic flt);
        logic [31:0] start;
        start = n_entries;
        for (int i = 0; i < 80 && n_entries === start; i++) begin
            @(posedge clock);
            #1;
        end
        if (n_entries === start) begin
            n_fail++;
            complete_run();
        end else begin
            chk(fetched_addr, exp_base + {22'h0, exc, 2'b00});
            chk({24'h0, active_exception_status}, {24'h0, exc});
            chk({23'h0, active_irq_num}, {23'h0, {1'b0, exc} - 9'h010});
            chk({27'h0, active_prio}, {27'h0, prio});
            chk({30'h0, active_is_system, active_is_fault}, {30'h0, sys, flt});
        end
    endtask : take

    // handler return drops back to thread
    task leave;
        @(posedge clock);
        handler_done <= 1'b1;
        @(posedge clock);
        handler_done <= 1'b0;
        #1;
        chk({24'h0, active_exception_status}, 32'h0);
    endtask : leave

    task t_reset_state;
        #1;
        chk({24'h0, active_exception_status}, 32'h1);
        chk({27'h0, active_prio}, 32'h1d);
        chk({23'h0, active_irq_num}, 32'h1f1);
        chk(vector_base_offset, 32'h0);
        chk(vec_addr, 32'h4);
        chk({31'h0, entry_req}, 32'h0);
        leave();
    endtask : t_reset_state

    // lowest and highest routed interrupts at the priority extremes, the next at 8
    task t_irqs;
        irq_prio[0] <= 4'h0;
        irq_prio[81] <= 4'hf;
        fire(8, 82'h1);
        take(8'h10, 5'h00, 1'b0, 1'b0);
        leave();
        fire(8, 82'h2);
        take(8'h11, 5'h08, 1'b0, 1'b0);
        leave();
        fire(8, 82'h1 << 81);
        take(8'h61, 5'h0f, 1'b0, 1'b0);
        leave();
    endtask : t_irqs

    // every system source, with a different fetch latency each time
    task t_system;
        logic [7:0] exc [8];
        exc = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0b, 8'h0e, 8'h0f};
        for (int k = 0; k < 8; k++) begin
            ack_wait <= 4'(k);
            fire(k, '0);
            take(exc[k], (k == 0) ? 5'h1e : (k == 1) ? 5'h1f : {1'b0, sys_prio[k - 2]},
                1'b1, k >= 1 && k <= 4);
            leave();
        end
        ack_wait <= 4'h0;
    endtask : t_system

    // disabled ones stay pending; fixed hard fault still enters
    task t_disable;
        sys_enable <= 6'h0;
        irq_enable <= '0;
        sys_prio[0] <= 4'h2;
        irq_prio[0] <= 4'h1;
        fire(2, '0);
        fire(8, 82'h1);
        repeat (20) @(posedge clock);
        #1;
        chk({31'h0, entry_req}, 32'h0);
        fire(1, '0);
        take(8'h03, 5'h1f, 1'b1, 1'b1);
        leave();
        sys_enable <= 6'h3f;
        irq_enable <= '1;
        take(8'h10, 5'h01, 1'b0, 1'b0);
        leave();
        take(8'h04, 5'h02, 1'b1, 1'b1);
        leave();
    endtask : t_disable

    // equal priorities: lowest number first, no preemption; urgent one preempts
    task t_equal;
        irq_prio[3] <= 4'h4;
        irq_prio[5] <= 4'h4;
        irq_prio[2] <= 4'h1;
        fire(8, 82'h28);
        take(8'h13, 5'h04, 1'b0, 1'b0);
        repeat (12) @(posedge clock);
        #1;
        chk({31'h0, entry_req}, 32'h0);
        leave();
        take(8'h15, 5'h04, 1'b0, 1'b0);
        fire(8, 82'h4);
        take(8'h12, 5'h01, 1'b0, 1'b0);
        leave();
    endtask : t_equal

    // asynchronous entry waits for a retired instruction, synchronous does not
    task t_grace;
        stall <= 1'b1;
        fire(5, '0);
        take(8'h0b, {1'b0, sys_prio[3]}, 1'b1, 1'b0);
        leave();
        fire(8, 82'h1);
        repeat (12) @(posedge clock);
        #1;
        chk({31'h0, entry_req}, 32'h0);
        stall <= 1'b0;
        take(8'h10, 5'h01, 1'b0, 1'b0);
        leave();
    endtask : t_grace

    // relocation with clamping, a fetch from the new base, then a warm reset
    task t_base;
        logic [31:0] wr [4];
        logic [31:0] ex [4];
        wr = '{32'h1234_5678, 32'h0000_0010, 32'h0000_00ff, 32'h0001_0080};
        ex = '{32'h03ff_ff80, 32'h0000_0080, 32'h0000_0080, 32'h0001_0080};
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            base_wr <= 1'b1;
            base_wdata <= wr[i];
            @(posedge clock);
            base_wr <= 1'b0;
            @(posedge clock);
            #1;
            chk(vector_base_offset, ex[i]);
        end
        exp_base = 32'h0001_0080;
        fire(8, 82'h1 << 81);
        take(8'h61, 5'h0f, 1'b0, 1'b0);
        leave();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        exp_base = 32'h0;
        t_reset_state();
    endtask : t_base

    initial begin
        rst_n = 1'b0;
        {nmi_req, hard_req, mem_req, bus_req, usage_req, svc_req, psv_req, tick_req} = 8'h0;
        irq_req = '0;
        irq_enable = '1;
        sys_enable = 6'h3f;
        foreach (sys_prio[i]) sys_prio[i] = 4'(i + 1);
        foreach (irq_prio[i]) irq_prio[i] = 4'h8;
        base_wr = 1'b0;
        base_wdata = 32'h0;
        handler_done = 1'b0;
        stall = 1'b0;
        ack_wait = 4'h0;
        exp_base = 32'h0;
        n_fail = 0;
        n_compared = 0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_reset_state();
        t_irqs();
        t_system();
        t_disable();
        t_equal();
        t_grace();
        t_base();
        complete_run();
    end
endmodule : evp_exception_map_tb
